// File: include/sfc_pkg.sv
// package for the synthesizer frequency control block
// assumes a single 40 MHz clock and a plain register port
package sfc_pkg;
  // register offsets (byte address on the plain port)
  localparam logic [7:0] ADDR_CARRIER_HI  = 8'h00;
  localparam logic [7:0] ADDR_CARRIER_MID = 8'h01;
  localparam logic [7:0] ADDR_CARRIER_LO  = 8'h02;
  localparam logic [7:0] ADDR_TRIM_HI     = 8'h03;
  localparam logic [7:0] ADDR_TRIM_LO     = 8'h04;
  localparam logic [7:0] ADDR_EST_HI      = 8'h05;
  localparam logic [7:0] ADDR_EST_LO      = 8'h06;
  localparam logic [7:0] ADDR_SYNTH_CFG   = 8'h07;
  localparam logic [7:0] ADDR_IF_CFG      = 8'h08;
  localparam logic [7:0] ADDR_CHAN_CFG    = 8'h09;
  localparam logic [7:0] ADDR_AUTOCAL     = 8'h0a;
  localparam logic [7:0] ADDR_CAL_CFG     = 8'h0b;
  localparam logic [7:0] ADDR_PIN0_CFG    = 8'h0c;
  localparam logic [7:0] ADDR_CAL_CTRL    = 8'h0d;
  localparam logic [7:0] ADDR_STROBE      = 8'h0e;
  localparam logic [7:0] ADDR_STATE       = 8'h0f;
  localparam logic [7:0] ADDR_VCO_HI      = 8'h10;
  localparam logic [7:0] ADDR_VCO_MID     = 8'h11;
  localparam logic [7:0] ADDR_VCO_LO      = 8'h12;
  localparam logic [7:0] ADDR_IF_RESULT   = 8'h13;

  // field positions
  localparam int SYNTH_CFG_LOCK_EN_BIT = 4;
  localparam int STROBE_CAL_BIT        = 0;
  localparam int STROBE_APPLY_BIT      = 1;
  localparam int STROBE_IDLE_BIT       = 2;
  localparam int STROBE_RX_BIT         = 3;
  localparam int STROBE_TX_BIT         = 4;
  localparam int STROBE_SYNTH_READY_FOR_TRANSMIT_STATE_BIT     = 5;
  localparam int STROBE_END_BIT        = 6;
  localparam int STROBE_SLEEP_BIT      = 7;
  localparam int CAL_CTRL_LOCK_BIT     = 0;
  localparam int CAL_CTRL_VALID_BIT    = 1;
  localparam int CAL_CTRL_LOST_BIT     = 2;

  // reset values and the pin 0 lock select code
  localparam logic [7:0] SYNTH_CFG_RESET = 8'h02;
  localparam logic [7:0] CAL_CFG_RESET   = 8'h00;
  localparam logic [5:0] PIN0_SEL_RESET  = 6'h00;
  localparam logic [5:0] PIN0_SEL_LOCK   = 6'h23;

  // timing counts
  localparam int CAL_TIME_US     = 100;
  localparam int CLK_MHZ         = 40;
  localparam int CAL_CYCLES      = CAL_TIME_US * CLK_MHZ;
  localparam int LOCK_BASE_CYCLES = 64;
  localparam logic [1:0] AUTOCAL_RETURNS = 2'h3;

  typedef enum logic [1:0] {
    SFC_CAL_NEVER      = 2'h0,
    SFC_CAL_ON_START   = 2'h1,
    SFC_CAL_ON_RETURN  = 2'h2,
    SFC_CAL_EVERY_4TH  = 2'h3
  } sfc_autocal_t;

  typedef enum logic [2:0] {
    SFC_IDLE   = 3'b000,
    SFC_CAL    = 3'b001,
    SFC_RX     = 3'b011,
    SFC_TX     = 3'b010,
    SFC_SYNTH_READY_FOR_TRANSMIT_STATE = 3'b110,
    SFC_SLEEP  = 3'b100
  } sfc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfc_bus_req_t;

  typedef struct packed {
    logic [23:0] carrier;
    logic [15:0] trim;
  } sfc_carrier_word_t;
endpackage

// File: sim/sfc_checker.sv
// port-level relations of the synth control block
// assumes one clk domain and async active-high reset
`timescale 1ns/1ps
module sfc_checker
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire sfc_pkg::sfc_bus_req_t bus_req,
  input wire logic [34:0]           vco_setting,
  input wire logic [4:0]            lo_divider,
  input wire logic                  band_code_valid,
  input wire logic signed [2:0]     if_sign,
  input wire logic [8:0]            if_divisor,
  input wire logic                  synth_cal_active,
  input wire logic                  synth_running,
  input wire logic                  pin0_out
);
  import sfc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  int unsigned cal_len_q;
  // length of the current calibration, too long to unroll
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_len_q <= 0;
    end else if (synth_cal_active) begin
      cal_len_q <= cal_len_q + 1;
    end else begin
      cal_len_q <= 0;
    end
  end
  AST_BAND_VALID: assert property (band_code_valid == (lo_divider != 5'h00))
    else $error("band valid flag disagrees with divider");
  AST_BAND_SET: assert property (band_code_valid |->
    lo_divider inside {5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18})
    else $error("divider outside the decoded set");
  AST_IF_ZERO: assert property ((if_sign == 3'sh0) == (if_divisor == 9'h000))
    else $error("zero intermediate frequency inconsistent");
  AST_IF_DIV: assert property (if_divisor != 9'h000 |-> if_divisor inside
    {9'h030, 9'h048, 9'h060, 9'h090, 9'h0c0, 9'h120, 9'h180})
    else $error("divisor not decimation times 4, 6 or 8");
  AST_CAL_EXCL: assert property (!(synth_cal_active && synth_running))
    else $error("calibrating while running");
  AST_MAN_CAL: assert property (bus_req.wr && bus_req.addr == ADDR_STROBE &&
    bus_req.wdata[STROBE_CAL_BIT] && !synth_running && !synth_cal_active
    |-> ##[1:3] synth_cal_active)
    else $error("manual calibrate strobe ignored");
  AST_CAL_LEN: assert property ($fell(synth_cal_active) |->
    cal_len_q inside {[CAL_CYCLES - 2:CAL_CYCLES + 2]})
    else $error("calibration length wrong");
  AST_IDLE_NOCAL: assert property (bus_req.wr && bus_req.addr == ADDR_STROBE &&
    bus_req.wdata == 8'h04 && synth_running |-> ##1 (!synth_cal_active) [*4])
    else $error("forced idle started a calibration");
  AST_PIN_IDLE: assert property (!synth_running && !$past(synth_running) &&
    !$past(synth_running, 2) |-> !pin0_out)
    else $error("lock shown outside active states");
  AST_VCO_HOLD: assert property ($changed(vco_setting) |->
    synth_running || synth_cal_active)
    else $error("vco setting changed while idle");
endmodule // sfc_checker

bind sfc_synth_ctrl sfc_checker u_sfc_checker (
  .clk              (clk),
  .reset            (reset),
  .bus_req          (bus_req),
  .vco_setting      (vco_setting),
  .lo_divider       (lo_divider),
  .band_code_valid  (band_code_valid),
  .if_sign          (if_sign),
  .if_divisor       (if_divisor),
  .synth_cal_active (synth_cal_active),
  .synth_running    (synth_running),
  .pin0_out         (pin0_out)
);

// File: sim/sfc_host_model.sv
// host model issuing register cycles on the plain port
// assumes calls are made one at a time from the bench sequence
`timescale 1ns/1ps
module sfc_host_model
(
  input  wire logic             clk,
  input  wire logic [7:0]       rdata,
  output sfc_pkg::sfc_bus_req_t bus_req
);
  import sfc_pkg::*;
  initial bus_req = '0;
  // one-cycle strobe, dropped after the taking edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] rd_val);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
    rd_val = rdata;
  endtask
endmodule // sfc_host_model

// File: sim/tb.sv
// self-checking bench for the synth control block
// assumes host model owns the register port, bench drives the rest
`timescale 1ns/1ps
module tb;
  import sfc_pkg::*;
  localparam logic [23:0] CARRIER = 24'h123456;
  logic               clk;
  logic               reset;
  sfc_bus_req_t       bus_req;
  logic [15:0]        trim_est;
  logic               est_valid;
  logic               phase_match;
  logic               auto_done;
  logic [7:0]         rdata;
  logic [34:0]        vco_setting;
  logic [4:0]         lo_divider;
  logic               band_code_valid;
  logic signed [2:0]  if_sign;
  logic [8:0]         if_divisor;
  logic               synth_cal_active;
  logic               synth_running;
  logic               pin0_out;
  logic               lock_lost;
  int                 fail_count;
  int                 tests_run;
  logic [7:0]         d;
  logic [7:0]         d2;
  logic [4:0]         band_div [16] = '{5'h00, 5'h00, 5'h04, 5'h00, 5'h08, 5'h00, 5'h0c,
    5'h00, 5'h10, 5'h00, 5'h14, 5'h18, 5'h00, 5'h00, 5'h00, 5'h00};
  int                 if_mult [8] = '{0, 4, 6, 8, 0, 4, 6, 8};
  int                 dec_fac [4] = '{12, 24, 48, 48};

  sfc_synth_ctrl dut (.clk(clk), .reset(reset), .bus_req(bus_req),
    .measured_trim_estimate(trim_est), .estimate_valid(est_valid),
    .pll_phase_match(phase_match), .rx_tx_done(auto_done), .rdata(rdata),
    .vco_setting(vco_setting), .lo_divider(lo_divider), .band_code_valid(band_code_valid),
    .if_sign(if_sign), .if_divisor(if_divisor), .synth_cal_active(synth_cal_active),
    .synth_running(synth_running), .pin0_out(pin0_out), .lock_lost(lock_lost));
  sfc_host_model host (.clk(clk), .rdata(rdata), .bus_req(bus_req));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [34:0] vco_exp(input logic [23:0] c, input logic [15:0] t);
    return {9'h000, c, 2'b00} + {{19{t[15]}}, t};
  endfunction

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // outputs lag state by one cycle, so three edges cover any write
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse_done();
    @(posedge clk);
    auto_done <= 1'b1;
    @(posedge clk);
    auto_done <= 1'b0;
  endtask

  // look for a calibration start, then ride it out
  task automatic cal_seen(input logic exp);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 10 && !seen; i++) begin
      @(posedge clk);
      seen = (synth_cal_active === 1'b1);
    end
    chk(35'(seen), 35'(exp));
    for (i = 0; i < CAL_CYCLES + 20 && synth_cal_active === 1'b1; i++) begin
      @(posedge clk);
    end
    chk(35'(synth_cal_active), 35'h0);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    trim_est = 16'h0000;
    est_valid = 1'b0;
    phase_match = 1'b0;
    auto_done = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk(vco_setting, 35'h0);
    chk(35'(rdata), 35'h0);
    host.read_reg(ADDR_SYNTH_CFG, d);
    chk(35'(d), 35'(SYNTH_CFG_RESET));
    host.read_reg(8'hff, d);
    chk(35'(d), 35'h0);
    for (int b = 0; b < 16; b++) begin
      host.write_reg(ADDR_SYNTH_CFG, 8'(b));
      settle();
      chk(35'(lo_divider), 35'(band_div[b]));
      chk(35'(band_code_valid), 35'(band_div[b] != 5'h00));
    end
    for (int s = 0; s < 4; s++) begin
      host.write_reg(ADDR_CHAN_CFG, 8'(s));
      for (int c = 0; c < 8; c++) begin
        host.write_reg(ADDR_IF_CFG, 8'(c));
        settle();
        chk({32'h0, if_sign}, (if_mult[c] == 0) ? 35'h0 : (c < 4) ? 35'h7 : 35'h1);
        chk(35'(if_divisor), 35'(if_mult[c] * dec_fac[s]));
      end
    end
    // calibrate once after power-up before any frequency is used
    host.write_reg(ADDR_STROBE, 8'h01);
    cal_seen(1'b1);
    // words written while idle must not reach the vco setting yet
    host.write_reg(ADDR_CARRIER_HI, CARRIER[23:16]);
    host.write_reg(ADDR_CARRIER_MID, CARRIER[15:8]);
    host.write_reg(ADDR_CARRIER_LO, CARRIER[7:0]);
    host.write_reg(ADDR_TRIM_HI, 8'hff);
    host.write_reg(ADDR_TRIM_LO, 8'h00);
    settle();
    chk(vco_setting, 35'h0);
    host.write_reg(ADDR_SYNTH_CFG, 8'h12);
    host.write_reg(ADDR_PIN0_CFG, {2'b00, PIN0_SEL_LOCK});
    // window of 128 cycles, so a stuck 64-cycle window shows early lock
    host.write_reg(ADDR_CAL_CFG, 8'h01);
    @(posedge clk);
    phase_match <= 1'b1;
    host.write_reg(ADDR_STROBE, 8'h08);
    settle();
    chk(35'(synth_running), 35'h1);
    chk(vco_setting, vco_exp(CARRIER, 16'hff00));
    repeat (70) @(posedge clk);
    chk(35'(pin0_out), 35'h0);
    repeat (60) @(posedge clk);
    chk(35'(pin0_out), 35'h1);
    host.read_reg(ADDR_CAL_CTRL, d);
    chk(35'(d), 35'h03);
    @(posedge clk);
    phase_match <= 1'b0;
    settle();
    chk(35'(pin0_out), 35'h0);
    chk(35'(lock_lost), 35'h1);
    host.write_reg(ADDR_CAL_CTRL, 8'h04);
    settle();
    chk(35'(lock_lost), 35'h0);
    @(posedge clk);
    trim_est <= 16'h0100;
    est_valid <= 1'b1;
    host.write_reg(ADDR_STROBE, 8'h02);
    settle();
    chk(vco_setting, vco_exp(CARRIER, 16'hff00));
    host.read_reg(ADDR_TRIM_HI, d);
    host.read_reg(ADDR_TRIM_LO, d2);
    chk(35'({d, d2}), 35'h0);
    host.write_reg(ADDR_AUTOCAL, 8'h02);
    host.write_reg(ADDR_STROBE, 8'h04);
    cal_seen(1'b0);
    chk(35'(synth_running), 35'h0);
    host.write_reg(ADDR_STROBE, 8'h08);
    settle();
    chk(vco_setting, vco_exp(CARRIER, 16'h0000));
    pulse_done();
    cal_seen(1'b1);
    host.write_reg(ADDR_AUTOCAL, 8'h01);
    host.write_reg(ADDR_STROBE, 8'h08);
    cal_seen(1'b1);
    host.write_reg(ADDR_AUTOCAL, 8'h00);
    host.write_reg(ADDR_STROBE, 8'h80);
    settle();
    host.write_reg(ADDR_STROBE, 8'h04);
    host.read_reg(ADDR_CAL_CTRL, d);
    chk(35'(d[CAL_CTRL_VALID_BIT]), 35'h1);
    // synth_ready_for_transmit_state, then tx, then an automatic end given by the strobe bit
    host.write_reg(ADDR_AUTOCAL, 8'h02);
    host.write_reg(ADDR_STROBE, 8'h20);
    settle();
    chk(35'(synth_running), 35'h1);
    host.write_reg(ADDR_STROBE, 8'h10);
    settle();
    chk(35'(synth_running), 35'h1);
    host.write_reg(ADDR_STROBE, 8'h40);
    cal_seen(1'b1);
    // second reset restarts the return counter from zero
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk(vco_setting, 35'h0);
    host.write_reg(ADDR_AUTOCAL, 8'h03);
    for (int i = 0; i < 4; i++) begin
      host.write_reg(ADDR_STROBE, 8'h08);
      settle();
      pulse_done();
      cal_seen(i == 3);
    end
    stop_test();
  end
endmodule // tb

// File: src/sfc_synth_ctrl.sv
// synthesizer frequency control: vco word, lo divider, if decode, calibration, lock
// assumes host drives the plain register port synchronously to clk
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sfc_synth_ctrl
  import sfc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire sfc_pkg::sfc_bus_req_t bus_req,
  input  wire logic [15:0]         measured_trim_estimate,
  input  wire logic                estimate_valid,
  input  wire logic                pll_phase_match,
  input  wire logic                rx_tx_done,
  output logic [7:0]               rdata,
  output logic [34:0]              vco_setting,
  output logic [4:0]               lo_divider,
  output logic                     band_code_valid,
  output logic signed [2:0]        if_sign,
  output logic [8:0]               if_divisor,
  output logic                     synth_cal_active,
  output logic                     synth_running,
  output logic                     pin0_out,
  output logic                     lock_lost
);
  import sfc_pkg::*;

  function automatic logic [4:0] band_divider(input logic [3:0] code);
    unique case (code)
      4'b0010: band_divider = 5'd4;
      4'b0100: band_divider = 5'd8;
      4'b0110: band_divider = 5'd12;
      4'b1000: band_divider = 5'd16;
      4'b1010: band_divider = 5'd20;
      4'b1011: band_divider = 5'd24;
      default: band_divider = 5'd0;
    endcase
  endfunction

  function automatic logic [5:0] dec_factor(input logic [1:0] sel);
    unique case (sel)
      2'h0:    dec_factor = 6'd12;
      2'h1:    dec_factor = 6'd24;
      default: dec_factor = 6'd48;
    endcase
  endfunction

  localparam int CAL_W = $clog2(CAL_CYCLES + 1);

  logic [7:0]  carrier_word_hi_q, carrier_word_mid_q, carrier_word_lo_q;
  logic [7:0]  carrier_trim_hi_q, carrier_trim_lo_q;
  logic [7:0]  synth_config_q, if_cfg_q, channel_width_config_q, cal_cfg_q;
  logic [1:0]  autocal_q;
  logic [5:0]  pin0_signal_select_q;
  logic        apply_pending_q;
  sfc_carrier_word_t   active_q;
  sfc_state_t  state_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic [1:0]  return_cnt_q;
  logic        cal_valid_q;
  logic        lock_q;
  logic [11:0] lock_cnt_q;
  logic        lock_lost_q;

  wire wr = bus_req.wr;
  wire [7:0] wd = bus_req.wdata;
  wire strobe_wr = wr && bus_req.addr == ADDR_STROBE;
  wire manual_synth_cal_strobe = strobe_wr && wd[STROBE_CAL_BIT];
  wire apply_estimate_strobe   = strobe_wr && wd[STROBE_APPLY_BIT];
  wire go_idle_strobe          = strobe_wr && wd[STROBE_IDLE_BIT];
  wire go_rx   = strobe_wr && wd[STROBE_RX_BIT];
  wire go_tx   = strobe_wr && wd[STROBE_TX_BIT];
  wire go_fstx = strobe_wr && wd[STROBE_SYNTH_READY_FOR_TRANSMIT_STATE_BIT];
  wire go_sleep = strobe_wr && wd[STROBE_SLEEP_BIT];
  wire auto_return = rx_tx_done || (strobe_wr && wd[STROBE_END_BIT]);
  wire active_state = state_q == SFC_RX || state_q == SFC_TX || state_q == SFC_SYNTH_READY_FOR_TRANSMIT_STATE;
  wire lock_detector_enable = synth_config_q[SYNTH_CFG_LOCK_EN_BIT];
  wire [3:0] lo_divider_band_code = synth_config_q[3:0];
  wire [2:0] intermediate_carrier_word_code = if_cfg_q[2:0];
  wire [1:0] decimation_select = channel_width_config_q[1:0];
  sfc_autocal_t auto_synth_cal_mode;
  assign auto_synth_cal_mode = sfc_autocal_t'(autocal_q);

  // configuration registers; host keeps them steady outside idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      carrier_word_hi_q      <= 8'h00;
      carrier_word_mid_q     <= 8'h00;
      carrier_word_lo_q      <= 8'h00;
      synth_config_q         <= SYNTH_CFG_RESET;
      if_cfg_q               <= 8'h00;
      channel_width_config_q <= 8'h00;
      autocal_q              <= 2'h0;
      cal_cfg_q              <= CAL_CFG_RESET;
      pin0_signal_select_q   <= PIN0_SEL_RESET;
    end else if (wr) begin
      unique case (bus_req.addr)
        ADDR_CARRIER_HI:  carrier_word_hi_q      <= wd;
        ADDR_CARRIER_MID: carrier_word_mid_q     <= wd;
        ADDR_CARRIER_LO:  carrier_word_lo_q      <= wd;
        ADDR_SYNTH_CFG:   synth_config_q         <= wd;
        ADDR_IF_CFG:      if_cfg_q               <= wd;
        ADDR_CHAN_CFG:    channel_width_config_q <= wd;
        ADDR_AUTOCAL:     autocal_q              <= wd[1:0];
        ADDR_CAL_CFG:     cal_cfg_q              <= wd;
        ADDR_PIN0_CFG:    pin0_signal_select_q   <= wd[5:0];
        default: ;
      endcase
    end
  end

  // trim word: host writes or estimate accumulates in place
  logic [15:0] trim_sum;
  assign trim_sum = {carrier_trim_hi_q, carrier_trim_lo_q} + measured_trim_estimate;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      carrier_trim_hi_q <= 8'h00;
      carrier_trim_lo_q <= 8'h00;
      apply_pending_q   <= 1'b0;
    end else begin
      if (wr && bus_req.addr == ADDR_TRIM_HI) carrier_trim_hi_q <= wd;
      if (wr && bus_req.addr == ADDR_TRIM_LO) carrier_trim_lo_q <= wd;
      if (apply_estimate_strobe && estimate_valid) begin
        // accepted in any state; applied at next active entry
        {carrier_trim_hi_q, carrier_trim_lo_q} <= trim_sum;
        apply_pending_q <= 1'b1;
      end else if (go_rx || go_tx) begin
        apply_pending_q <= 1'b0;
      end
    end
  end

  // snapshot words only on synth start, so half-written words never reach the vco
  wire synth_start = (state_q == SFC_IDLE || state_q == SFC_SYNTH_READY_FOR_TRANSMIT_STATE) && (go_rx || go_tx || go_fstx);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_q <= '0;
    end else if (synth_start) begin
      active_q.carrier <= {carrier_word_hi_q, carrier_word_mid_q, carrier_word_lo_q};
      active_q.trim    <= {carrier_trim_hi_q, carrier_trim_lo_q};
    end
  end

  // vco word in 2^-18 units of xosc; carrier shifted by 2 then signed trim added
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vco_setting <= 35'h0;
    end else begin
      vco_setting <= {9'h0, active_q.carrier, 2'b00}
                   + {{19{active_q.trim[15]}}, active_q.trim};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lo_divider      <= 5'd0;
      band_code_valid <= 1'b0;
    end else begin
      lo_divider      <= band_divider(lo_divider_band_code);
      band_code_valid <= band_divider(lo_divider_band_code) != 5'd0;
    end
  end

  // if = sign * xosc / (decimation * mult); divisor output so analog side divides
  logic [3:0] if_mult;
  always_comb begin
    unique case (intermediate_carrier_word_code[1:0])
      2'h1:    if_mult = 4'd4;
      2'h2:    if_mult = 4'd6;
      2'h3:    if_mult = 4'd8;
      default: if_mult = 4'd0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      if_sign    <= 3'sd0;
      if_divisor <= 9'd0;
    end else begin
      if_divisor <= 9'(dec_factor(decimation_select) * if_mult);
      if (if_mult == 4'd0)
        if_sign <= 3'sd0;
      else if (intermediate_carrier_word_code[2])
        if_sign <= 3'sd1;
      else
        if_sign <= -3'sd1;
    end
  end

  // radio state and calibration sequencing
  logic cal_request;
  always_comb begin
    cal_request = manual_synth_cal_strobe;
    if (state_q == SFC_IDLE && (go_rx || go_tx || go_fstx)
        && auto_synth_cal_mode == SFC_CAL_ON_START)
      cal_request = 1'b1;
    if ((state_q == SFC_RX || state_q == SFC_TX) && auto_return && !go_idle_strobe) begin
      if (auto_synth_cal_mode == SFC_CAL_ON_RETURN)
        cal_request = 1'b1;
      if (auto_synth_cal_mode == SFC_CAL_EVERY_4TH && return_cnt_q == AUTOCAL_RETURNS)
        cal_request = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q   <= SFC_IDLE;
      cal_cnt_q <= '0;
    end else begin
      unique case (state_q)
        SFC_IDLE: begin
          if (cal_request) begin
            state_q   <= SFC_CAL;
            cal_cnt_q <= CAL_W'(CAL_CYCLES);
          end else if (go_rx)   state_q <= SFC_RX;
          else if (go_tx)       state_q <= SFC_TX;
          else if (go_fstx)     state_q <= SFC_SYNTH_READY_FOR_TRANSMIT_STATE;
          else if (go_sleep)    state_q <= SFC_SLEEP;
        end
        SFC_CAL: begin
          if (go_idle_strobe) state_q <= SFC_IDLE;
          else if (cal_cnt_q == CAL_W'(1)) state_q <= SFC_IDLE;
          cal_cnt_q <= cal_cnt_q - CAL_W'(1);
        end
        SFC_RX, SFC_TX: begin
          if (go_idle_strobe) state_q <= SFC_IDLE;
          else if (auto_return) begin
            state_q   <= cal_request ? SFC_CAL : SFC_IDLE;
            cal_cnt_q <= CAL_W'(CAL_CYCLES);
          end
        end
        SFC_SYNTH_READY_FOR_TRANSMIT_STATE: begin
          if (go_idle_strobe) state_q <= SFC_IDLE;
          else if (go_rx)     state_q <= SFC_RX;
          else if (go_tx)     state_q <= SFC_TX;
        end
        SFC_SLEEP: if (go_idle_strobe) state_q <= SFC_IDLE;
        default: state_q <= SFC_IDLE;
      endcase
    end
  end

  // automatic-return counter; forced idle does not count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      return_cnt_q <= 2'h0;
    end else if ((state_q == SFC_RX || state_q == SFC_TX) && auto_return && !go_idle_strobe) begin
      return_cnt_q <= return_cnt_q + 2'h1;
    end
  end

  // cal result kept through sleep: only reset clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_valid_q <= 1'b0;
    end else if (state_q == SFC_CAL && cal_cnt_q == CAL_W'(1) && !go_idle_strobe) begin
      cal_valid_q <= 1'b1;
    end
  end

  // lock detector: phase match must hold for the averaging window
  wire [11:0] lock_window = 12'(LOCK_BASE_CYCLES << cal_cfg_q[1:0]);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_cnt_q <= 12'h0;
      lock_q     <= 1'b0;
    end else if (!lock_detector_enable || !active_state) begin
      lock_cnt_q <= 12'h0;
      lock_q     <= 1'b0;
    end else if (!pll_phase_match) begin
      lock_cnt_q <= 12'h0;
      lock_q     <= 1'b0;
    end else if (lock_cnt_q >= lock_window - 12'h1) begin
      lock_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 12'h1;
    end
  end

  // sticky lost flag; set beats a same-cycle write clear
  wire lost_event = lock_q && !pll_phase_match && lock_detector_enable && active_state;
  wire lost_clear = wr && bus_req.addr == ADDR_CAL_CTRL && wd[CAL_CTRL_LOST_BIT];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_lost_q <= 1'b0;
    end else if (lost_event) begin
      lock_lost_q <= 1'b1;
    end else if (lost_clear) begin
      lock_lost_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_cal_active <= 1'b0;
      synth_running    <= 1'b0;
      pin0_out         <= 1'b0;
      lock_lost        <= 1'b0;
    end else begin
      synth_cal_active <= state_q == SFC_CAL;
      synth_running    <= active_state;
      pin0_out         <= (pin0_signal_select_q == PIN0_SEL_LOCK) && lock_q;
      lock_lost        <= lock_lost_q;
    end
  end

  // read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CARRIER_HI:  rdata <= carrier_word_hi_q;
        ADDR_CARRIER_MID: rdata <= carrier_word_mid_q;
        ADDR_CARRIER_LO:  rdata <= carrier_word_lo_q;
        ADDR_TRIM_HI:     rdata <= carrier_trim_hi_q;
        ADDR_TRIM_LO:     rdata <= carrier_trim_lo_q;
        ADDR_EST_HI:      rdata <= measured_trim_estimate[15:8];
        ADDR_EST_LO:      rdata <= measured_trim_estimate[7:0];
        ADDR_SYNTH_CFG:   rdata <= synth_config_q;
        ADDR_IF_CFG:      rdata <= if_cfg_q;
        ADDR_CHAN_CFG:    rdata <= channel_width_config_q;
        ADDR_AUTOCAL:     rdata <= {6'h0, autocal_q};
        ADDR_CAL_CFG:     rdata <= cal_cfg_q;
        ADDR_PIN0_CFG:    rdata <= {2'h0, pin0_signal_select_q};
        ADDR_CAL_CTRL:    rdata <= {5'h0, lock_lost_q, cal_valid_q, lock_q};
        ADDR_STATE:       rdata <= {2'h0, apply_pending_q, return_cnt_q, state_q};
        ADDR_VCO_HI:      rdata <= {5'h0, vco_setting[34:32]} ;
        ADDR_VCO_MID:     rdata <= vco_setting[31:24];
        ADDR_VCO_LO:      rdata <= vco_setting[23:16];
        ADDR_IF_RESULT:   rdata <= {if_sign[1:0], 1'b0, lo_divider};
        default:          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // sfc_synth_ctrl
